// file: src/pmlc_regs.svh
// Register map, field positions, reset values and timing figures of the
// power monitor limit block. Definitions only; included by pmlc_top.
`ifndef PMLC_REGS_SVH
`define PMLC_REGS_SVH

// Byte offsets on the register bus
`define PMLC_CONFIG      8'h00
`define PMLC_ADC_CFG     8'h04
`define PMLC_SHUNT_CAL   8'h08
`define PMLC_SHUNT_RES   8'h0C
`define PMLC_BUS_RES     8'h10
`define PMLC_TEMP_RES    8'h14
`define PMLC_CURRENT     8'h18
`define PMLC_POWER       8'h1C
`define PMLC_SHUNT_LIM   8'h20
`define PMLC_BUS_LIM     8'h24
`define PMLC_TEMP_LIM    8'h28
`define PMLC_PWR_LIM     8'h2C
`define PMLC_STATUS      8'h30
`define PMLC_MASK        8'h34
`define PMLC_ALERT_CFG   8'h38

// Field positions
`define PMLC_RANGE_BIT   4
`define PMLC_MODE_LSB    12
`define PMLC_VBUS_CT_LSB 9
`define PMLC_VSH_CT_LSB  6
`define PMLC_VT_CT_LSB   3
`define PMLC_AVG_LSB     0
`define PMLC_ST_SHUNT    0
`define PMLC_ST_BUS      1
`define PMLC_ST_TEMP     2
`define PMLC_ST_PWR      3
`define PMLC_ST_CNVR     4

// Reset values
`define PMLC_ADC_CFG_RST 16'hFB68
`define PMLC_CAL_RST     15'h0000
`define PMLC_SLIM_RST    16'h7FFF
`define PMLC_BLIM_RST    16'h7FFF
`define PMLC_TLIM_RST    16'h7FFF
`define PMLC_PLIM_RST    16'hFFFF
`define PMLC_MASK_RST    5'h0F

// Conversion times in microseconds, per 3-bit code; MCLK period in nanoseconds
`define PMLC_CT0_US      50
`define PMLC_CT1_US      84
`define PMLC_CT2_US      150
`define PMLC_CT3_US      280
`define PMLC_CT4_US      540
`define PMLC_CT5_US      1052
`define PMLC_CT6_US      2074
`define PMLC_CT7_US      4120
`define PMLC_MCLK_NS     4

// Result scaling
`define PMLC_TEMP_STEP_MC 125
`define PMLC_BUS_STEP_UV  3125
`define PMLC_PLIM_SHIFT   8
`define PMLC_CUR_SHIFT    11
`define PMLC_NARROW_SHIFT 2
`define PMLC_PWR_MUL      13
`define PMLC_PWR_SHIFT    6

`endif

// file: src/pmlc_pkg.sv
// Types shared by the power monitor limit block.
// Assumes nothing beyond a SystemVerilog compiler.
package pmlc_pkg;
    typedef enum logic [1:0] {
        CH_SHUNT = 2'b00,
        CH_BUS   = 2'b01,
        CH_TEMP  = 2'b11
    } pmlc_chan_t;
    typedef logic signed [15:0] pmlc_res_t;
endpackage

// file: src/pmlc_top.sv
// Power monitor configuration, conversion sequencing and limit alerts.
// Assumes an AHB-Lite master, and ADC codes on MCLK from the front end.
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "pmlc_regs.svh"

// Function
// - Shunt and bus conversion times are set by separate fields.
// - The averaging count is a field of its own in the ADC setup register.
// - A register bit selects the wide or the narrow shunt input range.
// - From reset the wide range is used and all three channels convert in turn.
// - Current and power read zero while the calibration is unprogrammed.
// - Power is derived from current and the measured bus voltage.
// - Each fault condition has its own limit register, live once written.
// - The shunt limit is compared with the raw shunt result in its own step.
// - The bus limit is compared with the bus result at 3.125 mV per count.
// - The 16-bit power limit compares with the upper 16 of 24 power bits.
// - All limit registers return to their defaults at reset.
// - The alert shows either limit events or conversion ready, by setting.
// - Shunt, current, bus and temperature results are two's complement.
// - The temperature result steps 125 milli-degrees per count.
module pmlc_top #(
    parameter int CYC_PER_US = 1000 / `PMLC_MCLK_NS
) (
    input  wire logic        MCLK,
    input  wire logic        NRST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    input  wire logic [15:0] SHUNT_CODE,
    input  wire logic [15:0] BUS_CODE,
    input  wire logic [15:0] TEMP_CODE,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             ALERT,
    output logic             IRQ,
    output logic             RANGE_NARROW
);
    logic [1:0]          rst_sync;
    logic                rst_n;
    logic                wr_pend;
    logic [7:0]          waddr;
    logic [15:0]         adc_cfg;
    logic [14:0]         cal;
    logic [15:0]         lim_sh;
    logic [15:0]         lim_bus;
    logic [15:0]         lim_tmp;
    logic [15:0]         lim_pwr;
    logic [4:0]          mask;
    logic [4:0]          status;
    logic [4:0]          set;
    logic [4:0]          clr;
    logic                alert_sel;
    pmlc_pkg::pmlc_chan_t chan;
    pmlc_pkg::pmlc_chan_t next_chan;
    logic [31:0]         conv_cnt;
    int                  conv_len;
    logic                conv_end;
    logic [10:0]         avg_cnt;
    logic [3:0]          shift;
    logic                avg_last;
    logic signed [25:0]  acc;
    logic signed [25:0]  sum;
    logic [15:0]         sample;
    pmlc_pkg::pmlc_res_t avg_val;
    logic [2:0]          mode;
    logic                active;
    logic                done;
    pmlc_pkg::pmlc_res_t res_sh;
    pmlc_pkg::pmlc_res_t res_bus;
    pmlc_pkg::pmlc_res_t res_tmp;
    pmlc_pkg::pmlc_res_t cur;
    logic [23:0]         pwr;
    logic [2:0]          pw_chk;
    logic signed [31:0]  prod;
    logic [15:0]         cur_abs;
    logic [15:0]         bus_pos;
    logic [35:0]         p36;
    logic [31:0]         rd_val;

    function automatic int ct_us(input logic [2:0] c);
        unique case (c)
            3'h0: ct_us = `PMLC_CT0_US;
            3'h1: ct_us = `PMLC_CT1_US;
            3'h2: ct_us = `PMLC_CT2_US;
            3'h3: ct_us = `PMLC_CT3_US;
            3'h4: ct_us = `PMLC_CT4_US;
            3'h5: ct_us = `PMLC_CT5_US;
            3'h6: ct_us = `PMLC_CT6_US;
            3'h7: ct_us = `PMLC_CT7_US;
        endcase
    endfunction

    // Sample counts 1,4,16,64,128,256,512,1024 are all powers of two
    function automatic logic [3:0] avg_shift(input logic [2:0] a);
        unique case (a)
            3'h0: avg_shift = 4'h0;
            3'h1: avg_shift = 4'h2;
            3'h2: avg_shift = 4'h4;
            3'h3: avg_shift = 4'h6;
            3'h4: avg_shift = 4'h7;
            3'h5: avg_shift = 4'h8;
            3'h6: avg_shift = 4'h9;
            3'h7: avg_shift = 4'hA;
        endcase
    endfunction

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend   <= 1'b0;
            waddr     <= 8'h00;
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            wr_pend   <= HSEL && HREADY && HTRANS[1] && HWRITE;
            waddr     <= HADDR[7:0];
            if (HSEL && HREADY && HTRANS[1] && !HWRITE)
                HRDATA <= rd_val;
        end
    end

    always_comb
    begin
        unique case (HADDR[7:0])
            `PMLC_CONFIG:    rd_val = 32'(RANGE_NARROW) << `PMLC_RANGE_BIT;
            `PMLC_ADC_CFG:   rd_val = {16'h0000, adc_cfg};
            `PMLC_SHUNT_CAL: rd_val = {17'h0_0000, cal};
            `PMLC_SHUNT_RES: rd_val = {16'h0000, res_sh};
            `PMLC_BUS_RES:   rd_val = {16'h0000, res_bus};
            `PMLC_TEMP_RES:  rd_val = {16'h0000, res_tmp};
            `PMLC_CURRENT:   rd_val = {16'h0000, cur};
            `PMLC_POWER:     rd_val = {8'h00, pwr};
            `PMLC_SHUNT_LIM: rd_val = {16'h0000, lim_sh};
            `PMLC_BUS_LIM:   rd_val = {16'h0000, lim_bus};
            `PMLC_TEMP_LIM:  rd_val = {16'h0000, lim_tmp};
            `PMLC_PWR_LIM:   rd_val = {16'h0000, lim_pwr};
            `PMLC_STATUS:    rd_val = {27'h000_0000, status};
            `PMLC_MASK:      rd_val = {27'h000_0000, mask};
            `PMLC_ALERT_CFG: rd_val = {31'h0000_0000, alert_sel};
            default:         rd_val = 32'h0000_0000;
        endcase
    end

    // Setup and limit registers; defaults at every reset
    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            RANGE_NARROW <= 1'b0;
            adc_cfg      <= `PMLC_ADC_CFG_RST;
            cal          <= `PMLC_CAL_RST;
            lim_sh       <= `PMLC_SLIM_RST;
            lim_bus      <= `PMLC_BLIM_RST;
            lim_tmp      <= `PMLC_TLIM_RST;
            lim_pwr      <= `PMLC_PLIM_RST;
            mask         <= `PMLC_MASK_RST;
            alert_sel    <= 1'b0;
        end
        else if (wr_pend)
        begin
            unique case (waddr)
                `PMLC_CONFIG:    RANGE_NARROW <= HWDATA[`PMLC_RANGE_BIT];
                `PMLC_ADC_CFG:   adc_cfg <= HWDATA[15:0];
                `PMLC_SHUNT_CAL: cal     <= HWDATA[14:0];
                `PMLC_SHUNT_LIM: lim_sh  <= HWDATA[15:0];
                `PMLC_BUS_LIM:   lim_bus <= HWDATA[15:0];
                `PMLC_TEMP_LIM:  lim_tmp <= HWDATA[15:0];
                `PMLC_PWR_LIM:   lim_pwr <= HWDATA[15:0];
                `PMLC_MASK:      mask    <= HWDATA[4:0];
                `PMLC_ALERT_CFG: alert_sel <= HWDATA[0];
                default:         ;
            endcase
        end
    end

    // Conversion sequencer
    assign mode   = adc_cfg[`PMLC_MODE_LSB +: 3];
    assign active = |mode;
    assign shift  = avg_shift(adc_cfg[`PMLC_AVG_LSB +: 3]);

    always_comb
    begin
        unique case (chan)
            pmlc_pkg::CH_SHUNT:
                conv_len = ct_us(adc_cfg[`PMLC_VSH_CT_LSB +: 3]) * CYC_PER_US;
            pmlc_pkg::CH_BUS:
                conv_len = ct_us(adc_cfg[`PMLC_VBUS_CT_LSB +: 3]) * CYC_PER_US;
            default:
                conv_len = ct_us(adc_cfg[`PMLC_VT_CT_LSB +: 3]) * CYC_PER_US;
        endcase
    end

    always_comb
    begin
        unique case (chan)
            pmlc_pkg::CH_SHUNT: sample = SHUNT_CODE;
            pmlc_pkg::CH_BUS:   sample = BUS_CODE;
            default:            sample = TEMP_CODE;
        endcase
    end

    // Round robin over enabled channels: shunt, bus, temperature
    always_comb
    begin
        unique case (chan)
            pmlc_pkg::CH_SHUNT:
                next_chan = mode[1] ? pmlc_pkg::CH_BUS :
                            mode[2] ? pmlc_pkg::CH_TEMP : pmlc_pkg::CH_SHUNT;
            pmlc_pkg::CH_BUS:
                next_chan = mode[2] ? pmlc_pkg::CH_TEMP :
                            mode[0] ? pmlc_pkg::CH_SHUNT : pmlc_pkg::CH_BUS;
            pmlc_pkg::CH_TEMP:
                next_chan = mode[0] ? pmlc_pkg::CH_SHUNT :
                            mode[1] ? pmlc_pkg::CH_BUS : pmlc_pkg::CH_TEMP;
            default:
                next_chan = pmlc_pkg::CH_SHUNT;
        endcase
    end

    // At or past the end, so a shorter setting written mid-conversion cannot skip it
    assign conv_end = conv_cnt >= 32'(conv_len - 1);
    assign avg_last = avg_cnt >= ((11'h001 << shift) - 11'h001);
    assign sum      = acc + 26'($signed(sample));
    assign avg_val  = 16'(sum >>> shift);
    assign done     = active && conv_end && avg_last;

    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan     <= pmlc_pkg::CH_SHUNT;
            conv_cnt <= 32'h0000_0000;
            avg_cnt  <= 11'h000;
            acc      <= 26'h000_0000;
        end
        else if (!active)
        begin
            conv_cnt <= 32'h0000_0000;
            avg_cnt  <= 11'h000;
            acc      <= 26'h000_0000;
        end
        else if (conv_end)
        begin
            conv_cnt <= 32'h0000_0000;
            if (avg_last)
            begin
                avg_cnt <= 11'h000;
                acc     <= 26'h000_0000;
                chan    <= next_chan;
            end
            else
            begin
                avg_cnt <= avg_cnt + 11'h001;
                acc     <= sum;
            end
        end
        else
            conv_cnt <= conv_cnt + 32'h0000_0001;
    end

    // Results in two's complement; temperature in 125 m-degC counts
    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            res_sh  <= 16'h0000;
            res_bus <= 16'h0000;
            res_tmp <= 16'h0000;
        end
        else if (done)
        begin
            unique case (chan)
                pmlc_pkg::CH_SHUNT: res_sh  <= avg_val;
                pmlc_pkg::CH_BUS:   res_bus <= avg_val;
                default:            res_tmp <= avg_val;
            endcase
        end
    end

    // Narrow range has a four times finer shunt step
    assign prod    = $signed(res_sh) * $signed({1'b0, cal});
    assign cur_abs = cur[15] ? 16'(-cur) : cur;
    assign bus_pos = res_bus[15] ? 16'h0000 : res_bus;
    assign p36     = 36'(cur_abs) * 36'(bus_pos) * 36'(`PMLC_PWR_MUL);

    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur <= 16'h0000;
            pwr <= 24'h00_0000;
        end
        else
        begin
            if (cal == `PMLC_CAL_RST)
                cur <= 16'h0000;
            else if (RANGE_NARROW)
                cur <= 16'(prod >>> (`PMLC_CUR_SHIFT + `PMLC_NARROW_SHIFT));
            else
                cur <= 16'(prod >>> `PMLC_CUR_SHIFT);
            // Saturate rather than wrap a power overflow
            pwr <= (|p36[35:30]) ? 24'hFF_FFFF : p36[29:6];
        end
    end

    // Power check three cycles after the result, once current and power have caught up
    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
            pw_chk <= 3'h0;
        else
            pw_chk <= {pw_chk[1:0], done && chan != pmlc_pkg::CH_TEMP};
    end

    always_comb
    begin
        set = 5'h00;
        set[`PMLC_ST_SHUNT] = done && chan == pmlc_pkg::CH_SHUNT
                              && avg_val > $signed(lim_sh);
        set[`PMLC_ST_BUS]   = done && chan == pmlc_pkg::CH_BUS
                              && avg_val > $signed(lim_bus);
        set[`PMLC_ST_TEMP]  = done && chan == pmlc_pkg::CH_TEMP
                              && avg_val > $signed(lim_tmp);
        set[`PMLC_ST_PWR]   = pw_chk[2]
                              && pwr[23:`PMLC_PLIM_SHIFT] > lim_pwr;
        set[`PMLC_ST_CNVR]  = done;
    end

    assign clr = (wr_pend && waddr == `PMLC_STATUS) ? HWDATA[4:0] : 5'h00;

    // A new event beats a write-one-to-clear in the same cycle
    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
            status <= 5'h00;
        else
            status <= (status & ~clr) | set;
    end

    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ALERT <= 1'b0;
            IRQ   <= 1'b0;
        end
        else
        begin
            ALERT <= alert_sel ? status[`PMLC_ST_CNVR] & mask[`PMLC_ST_CNVR]
                               : |(status[3:0] & mask[3:0]);
            IRQ   <= |(status & mask);
        end
    end

    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!rst_n);

    cal_zero_a: assert property ((cal == 15'h0000) |=> (cur == 16'h0000))
        else $error("current not zero without calibration");
    pwr_zero_a: assert property ((cal == 15'h0000)[*3] |-> (pwr == 24'h00_0000))
        else $error("power not zero without calibration");
    reset_default_a: assert property ($rose(rst_n) |-> !RANGE_NARROW
        && mode == 3'h7 && lim_pwr == `PMLC_PLIM_RST)
        else $error("wrong setup after reset");
    seq_order_a: assert property (done && chan == pmlc_pkg::CH_SHUNT && mode[1]
        |=> chan == pmlc_pkg::CH_BUS)
        else $error("bus conversion did not follow shunt");
    avg_hold_a: assert property (active && conv_end && !avg_last
        |=> $stable(chan) && conv_cnt == 32'h0000_0000)
        else $error("channel left before averaging ended");
    shunt_lim_a: assert property (done && chan == pmlc_pkg::CH_SHUNT
        && avg_val > $signed(lim_sh) |=> status[`PMLC_ST_SHUNT] ##1 !mask[0] || ALERT
        || alert_sel)
        else $error("shunt over-limit not flagged");
    bus_lim_a: assert property (done && chan == pmlc_pkg::CH_BUS
        && avg_val > $signed(lim_bus) |=> status[`PMLC_ST_BUS])
        else $error("bus over-limit not flagged");
    pwr_lim_a: assert property (pw_chk[2] && pwr[23:8] > lim_pwr
        |=> status[`PMLC_ST_PWR])
        else $error("power over-limit not flagged");
    alert_sel_a: assert property (alert_sel && $stable(alert_sel)
        && !$past(status[`PMLC_ST_CNVR]) |-> !ALERT)
        else $error("limit event shown in ready mode");

    done_c: cover property (done && chan == pmlc_pkg::CH_TEMP);
    pwr_c: cover property (set[`PMLC_ST_PWR]);
    alert_c: cover property ($rose(ALERT));
    clr_c: cover property (|(set & clr));
endmodule

// file: verif/pmlc_host_bfm.sv
// Host model: AHB-Lite master doing single whole-word transfers.
// Assumes one slave whose HREADYOUT is fed back as hready.
`timescale 1ns/1ps
module pmlc_host_bfm (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // No cycle count assumed: only the bench watchdog ends a stalled wait
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
endmodule

// file: verif/tb.sv
// Self-checking bench for the power monitor limit block.
// Assumes the host model on the register bus; ADC codes are driven here.
`timescale 1ns/1ps
`include "pmlc_regs.svh"
module tb;
    localparam logic [31:0] ZW = 32'h0000_0000;
    logic        mclk;
    logic        nrst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        alert;
    logic        irq;
    logic        narrow;
    logic [15:0] sh;
    logic [15:0] vb;
    logic [15:0] tc;
    logic [31:0] rdv;
    logic [31:0] cfg;
    logic [14:0] cal;
    logic [15:0] cur;
    int          n_fail;
    int          compares;

    always #2 mclk = ~mclk;

    pmlc_top #(
        .CYC_PER_US (1)
    ) i_dut (
        .MCLK         (mclk),
        .NRST         (nrst),
        .HSEL         (hsel),
        .HADDR        (haddr),
        .HTRANS       (htrans),
        .HWRITE       (hwrite),
        .HSIZE        (hsize),
        .HWDATA       (hwdata),
        .HREADY       (hready),
        .SHUNT_CODE   (sh),
        .BUS_CODE     (vb),
        .TEMP_CODE    (tc),
        .HRDATA       (hrdata),
        .HREADYOUT    (hready),
        .HRESP        (hresp),
        .ALERT        (alert),
        .IRQ          (irq),
        .RANGE_NARROW (narrow)
    );

    pmlc_host_bfm i_host (
        .clk    (mclk),
        .hready (hready),
        .hrdata (hrdata),
        .hsel   (hsel),
        .haddr  (haddr),
        .htrans (htrans),
        .hwrite (hwrite),
        .hsize  (hsize),
        .hwdata (hwdata)
    );

    function automatic logic [15:0] exp_cur(input logic [15:0] s, input logic [14:0] c,
                                            input logic n);
        longint p;
        p = longint'($signed(s)) * longint'(c);
        if (c == 15'h0000)
            return 16'h0000;
        return n ? 16'(p >>> 13) : 16'(p >>> 11);
    endfunction

    // Magnitude of current times bus, clipped to the 24-bit result
    function automatic logic [23:0] exp_pwr(input logic [15:0] c, input logic [15:0] b);
        longint m;
        m = $signed(c);
        if (m < 0)
            m = -m;
        m = (m * longint'(b) * 13) >>> 6;
        return (m > 24'hFF_FFFF) ? 24'hFF_FFFF : 24'(m);
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic got, input logic exp);
        cmp({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, rdv);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        i_host.xfer(1'b0, a, ZW, rdv);
        cmp(rdv, exp);
        cmp_pin(hresp, 1'b0);
    endtask

    // Four fresh results, so every enabled channel has converted once
    task automatic wait_round();
        repeat (4)
        begin
            wr(`PMLC_STATUS, 32'h0000_0010);
            rdv = ZW;
            while (rdv[4] !== 1'b1) i_host.xfer(1'b0, `PMLC_STATUS, ZW, rdv);
        end
    endtask

    task automatic lims(input logic [31:0] s, input logic [31:0] b, input logic [31:0] t,
                        input logic [31:0] p);
        wr(`PMLC_SHUNT_LIM, s);
        wr(`PMLC_BUS_LIM, b);
        wr(`PMLC_TEMP_LIM, t);
        wr(`PMLC_PWR_LIM, p);
    endtask

    task automatic chk(input logic [31:0] st, input logic pin);
        wait_round();
        i_host.xfer(1'b0, `PMLC_STATUS, ZW, rdv);
        cmp(rdv & 32'h0000_000F, st);
        cmp_pin(alert, pin);
        cmp_pin(irq, pin);
    endtask

    task automatic final_report();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #(40000 * 4);
        n_fail++;
        final_report();
    end

    initial
    begin
        mclk = 1'b0;
        nrst = 1'b0;
        sh = 16'h0000;
        vb = 16'h0000;
        tc = 16'h0000;
        n_fail = 0;
        compares = 0;
        void'($urandom(32'hf506));
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        sh <= 16'hFF9C;
        vb <= 16'h0320;
        tc <= 16'h00C8;
        cmp_pin(narrow, 1'b0);
        rd(`PMLC_CONFIG, ZW);
        rd(`PMLC_ADC_CFG, 32'h0000_FB68);
        rd(`PMLC_SHUNT_CAL, ZW);
        rd(`PMLC_SHUNT_LIM, 32'h0000_7FFF);
        rd(`PMLC_BUS_LIM, 32'h0000_7FFF);
        rd(`PMLC_TEMP_LIM, 32'h0000_7FFF);
        rd(`PMLC_PWR_LIM, 32'h0000_FFFF);
        rd(`PMLC_MASK, 32'h0000_000F);
        rd(8'h3C, ZW);
        wait_round();
        rd(`PMLC_SHUNT_RES, 32'h0000_FF9C);
        rd(`PMLC_BUS_RES, 32'h0000_0320);
        rd(`PMLC_TEMP_RES, 32'h0000_00C8);
        rd(`PMLC_CURRENT, ZW);
        rd(`PMLC_POWER, ZW);
        $display("test power-up defaults done");
        cfg = 32'h0000_7000 | ($urandom & 32'h0000_0FFF);
        wr(`PMLC_ADC_CFG, cfg);
        rd(`PMLC_ADC_CFG, cfg);
        // Fastest setting before any slow sample can finish
        wr(`PMLC_ADC_CFG, 32'h0000_7000);
        wr(`PMLC_CONFIG, 32'h0000_0010);
        rd(`PMLC_CONFIG, 32'h0000_0010);
        cmp_pin(narrow, 1'b1);
        $display("test setup fields done");
        for (int i = 0; i < 6; i++)
        begin
            sh <= 16'($urandom_range(8190)) - 16'h0FFF;
            vb <= 16'($urandom_range(16383));
            cal = 15'($urandom_range(4095, 1));
            wr(`PMLC_CONFIG, {27'h000_0000, i[0], 4'h0});
            wr(`PMLC_SHUNT_CAL, {17'h0_0000, cal});
            wait_round();
            cur = exp_cur(sh, cal, i[0]);
            cmp_pin(narrow, i[0]);
            rd(`PMLC_SHUNT_RES, {16'h0000, sh});
            rd(`PMLC_CURRENT, {16'h0000, cur});
            rd(`PMLC_POWER, {8'h00, exp_pwr(cur, vb)});
        end
        $display("test current and power done");
        sh <= 16'hFF01;
        vb <= 16'h03E8;
        tc <= 16'h00C8;
        wr(`PMLC_CONFIG, ZW);
        wr(`PMLC_SHUNT_CAL, 32'h0000_0800);
        // Stale shunt or bus results would skew the first power check
        wait_round();
        lims(32'h0000_FF00, 32'h0000_03E8, 32'h0000_00C8, 32'h0000_00CA);
        wr(`PMLC_STATUS, 32'h0000_000F);
        chk(32'h0000_0001, 1'b1);
        lims(32'h0000_7FFF, 32'h0000_03E7, 32'h0000_00C7, 32'h0000_00C9);
        wr(`PMLC_STATUS, 32'h0000_000F);
        chk(32'h0000_000E, 1'b1);
        lims(32'h0000_7FFF, 32'h0000_7FFF, 32'h0000_7FFF, 32'h0000_FFFF);
        chk(32'h0000_000E, 1'b1);
        wr(`PMLC_STATUS, 32'h0000_000F);
        chk(ZW, 1'b0);
        $display("test limits done");
        wr(`PMLC_ALERT_CFG, 32'h0000_0001);
        wr(`PMLC_MASK, 32'h0000_0010);
        chk(ZW, 1'b1);
        wr(`PMLC_MASK, ZW);
        repeat (2) @(posedge mclk);
        cmp_pin(alert, 1'b0);
        cmp_pin(irq, 1'b0);
        wr(`PMLC_BUS_LIM, 32'h0000_03E7);
        wr(`PMLC_MASK, 32'h0000_000F);
        wait_round();
        repeat (2) @(posedge mclk);
        cmp_pin(alert, 1'b0);
        cmp_pin(irq, 1'b1);
        $display("test alert select done");
        // Bus only, four-sample average of a steady code
        vb <= 16'($urandom_range(16383));
        wr(`PMLC_ADC_CFG, 32'h0000_2001);
        wait_round();
        rd(`PMLC_BUS_RES, {16'h0000, vb});
        $display("test averaging done");
        final_report();
    end
endmodule
